// file: core/spi_port_device.sv
// SPI port, controller or target role, with APB register access
// ----------------------------------------
// ----------------------------------------
//
// The implementer's own choices: the register addresses and register access over APB.
`timescale 1ns/100ps
`include "spi_port_consts.svh"

module spi_port_device (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic irq,
    output logic wake,
    spi_link_if.device link
);
    import spi_port_pkg::*;

    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [7:0] ctrl_r;
    logic [4:0] pins_r;
    logic dbl_r, transfer_done_flag_r, write_collision_flag_r, armed_r, busy_r, out_r, sck_r, sck_prev_r, wake_r;
    byte_t sh_r, rx_buf_r;
    logic [2:0] bit_cnt_r;
    logic [7:0] div_cnt_r;
    logic [31:0] prdata_r;
    logic [3:0] sync1_r, sync2_r;
    logic [3:0] pin_in;

    // ----------------------------------------
    // Pin synchronisers
    // ----------------------------------------
    assign pin_in = {link.ss_n, link.miso, link.mosi, link.sck};

    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++) begin : g_sync
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    sync1_r[gi] <= 1'b0;
                    sync2_r[gi] <= 1'b0;
                end else begin
                    sync1_r[gi] <= pin_in[gi];
                    sync2_r[gi] <= sync1_r[gi];
                end
            end
        end
    endgenerate

    wire sck_s = sync2_r[0];
    wire mosi_s = sync2_r[1];
    wire miso_s = sync2_r[2];
    wire ss_s = sync2_r[3];

    // ----------------------------------------
    // APB decode
    // ----------------------------------------
    wire acc = psel & penable;
    wire wr = acc & pwrite;
    wire rd = acc & ~pwrite;
    wire sel_ctrl = paddr == `ADDR_CTRL;
    wire sel_stat = paddr == `ADDR_STATUS;
    wire sel_data = paddr == `ADDR_DATA;
    wire sel_pins = paddr == `ADDR_PINS;
    wire mapped = sel_ctrl | sel_stat | sel_data | sel_pins;
    wire data_wr = wr & sel_data;
    wire data_acc = acc & sel_data;
    wire stat_rd = rd & sel_stat;

    // ----------------------------------------
    // Control fields
    // ----------------------------------------
    wire enabled = ctrl_r[`CTRL_PORT_EN];
    wire is_ctrl = ctrl_r[`CTRL_CONTROLLER];
    wire cpol = ctrl_r[`CTRL_CPOL];
    wire cpha = ctrl_r[`CTRL_CPHA];
    wire lsb_first = ctrl_r[`CTRL_BIT_ORDER];
    wire [2:0] rate_sel = {dbl_r, ctrl_r[`CTRL_RATE_HI], ctrl_r[`CTRL_RATE_LO]};

    // Divisor table; /64 appears twice, hence seven distinct rates
    wire [7:0] sck_div = (rate_sel == 3'd0) ? `SCK_DIV_0 :
                         (rate_sel == 3'd1) ? `SCK_DIV_1 :
                         (rate_sel == 3'd2) ? `SCK_DIV_2 :
                         (rate_sel == 3'd3) ? `SCK_DIV_3 :
                         (rate_sel == 3'd4) ? `SCK_DIV_4 :
                         (rate_sel == 3'd5) ? `SCK_DIV_5 :
                         (rate_sel == 3'd6) ? `SCK_DIV_6 : `SCK_DIV_7;
    wire [7:0] half_m1 = {1'b0, sck_div[7:1]} - 8'd1;

    // ----------------------------------------
    // Edge events, both roles
    // ----------------------------------------
    // Mode fault: select pin is input and pulled low while controller
    wire mode_fault = enabled & is_ctrl & ~pins_r[`PIN_DIR_SS] & ~ss_s;
    wire tgt_sel = enabled & ~is_ctrl & ~ss_s;
    wire t_lead = tgt_sel & (sck_prev_r == cpol) & (sck_s != cpol);
    wire t_trail = tgt_sel & (sck_prev_r != cpol) & (sck_s == cpol);
    wire c_tick = enabled & is_ctrl & busy_r & (div_cnt_r == half_m1);
    wire c_lead = c_tick & (sck_r == cpol);
    wire c_trail = c_tick & (sck_r != cpol);
    wire lead = c_lead | t_lead;
    wire trail = c_trail | t_trail;
    wire sample = cpha ? trail : lead;
    wire setup = cpha ? lead : trail;
    wire in_bit = is_ctrl ? miso_s : mosi_s;
    wire [7:0] sh_shift = lsb_first ? {in_bit, sh_r[7:1]} : {sh_r[6:0], in_bit};
    wire top_bit = lsb_first ? sh_r[0] : sh_r[7];
    wire done = trail & (bit_cnt_r == 3'd7);

    // Transmit path holds one byte; a write while shifting only flags
    wire collide = data_wr & busy_r;
    wire load = data_wr & ~busy_r;
    wire start = load & enabled & is_ctrl & ~mode_fault;
    wire idle_reset = ~enabled | mode_fault | (~is_ctrl & ss_s);
    wire flag_clr = data_acc & armed_r;

    // ----------------------------------------
    // Software registers
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= `CTRL_RESET;
            pins_r <= `PINS_RESET;
            dbl_r <= `DOUBLE_RESET;
        end else begin
            if (wr & sel_ctrl) begin
                ctrl_r <= pwdata[7:0];
            end
            // Hardware fall-back overrides a same-cycle software write
            if (mode_fault) begin
                ctrl_r[`CTRL_CONTROLLER] <= 1'b0;
            end
            if (wr & sel_pins) begin
                pins_r <= pwdata[4:0];
            end
            if (wr & sel_stat) begin
                dbl_r <= pwdata[`STAT_DOUBLE];
            end
        end
    end

    // ----------------------------------------
    // Flags; a set in the clearing cycle wins
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            transfer_done_flag_r <= 1'b0;
            write_collision_flag_r <= 1'b0;
            armed_r <= 1'b0;
            wake_r <= 1'b0;
        end else begin
            transfer_done_flag_r <= done | mode_fault | (transfer_done_flag_r & ~flag_clr);
            write_collision_flag_r <= collide | (write_collision_flag_r & ~flag_clr);
            if (stat_rd & (transfer_done_flag_r | write_collision_flag_r)) begin
                armed_r <= 1'b1;
            end else if (data_acc) begin
                armed_r <= 1'b0;
            end
            wake_r <= done;
        end
    end

    // ----------------------------------------
    // Shifter, bit counter and SCK generator
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_r <= `DATA_RESET;
            rx_buf_r <= `DATA_RESET;
            out_r <= 1'b0;
            bit_cnt_r <= 3'd0;
            busy_r <= 1'b0;
            div_cnt_r <= 8'd0;
            sck_r <= 1'b0;
            sck_prev_r <= 1'b0;
        end else begin
            sck_prev_r <= idle_reset ? cpol : sck_s; // Idle level, so select brings no false edge
            if (load) begin
                // Unselected target may still be loaded
                sh_r <= pwdata[7:0];
                out_r <= lsb_first ? pwdata[0] : pwdata[7];
                bit_cnt_r <= 3'd0;
                busy_r <= start;
                div_cnt_r <= 8'd0;
            end else if (idle_reset) begin
                // Select high drops any partial byte
                bit_cnt_r <= 3'd0;
                busy_r <= 1'b0;
                div_cnt_r <= 8'd0;
            end else begin
                if (sample) begin
                    sh_r <= sh_shift;
                end
                if (setup) begin
                    out_r <= top_bit;
                end
                if (t_lead) begin
                    busy_r <= 1'b1;
                end
                if (trail) begin
                    bit_cnt_r <= bit_cnt_r + 3'd1;
                end
                if (done) begin
                    busy_r <= 1'b0;
                    rx_buf_r <= sample ? sh_shift : sh_r;
                end
                if (c_tick) begin
                    div_cnt_r <= 8'd0;
                end else if (busy_r & is_ctrl) begin
                    div_cnt_r <= div_cnt_r + 8'd1;
                end
            end
            if (c_tick & ~idle_reset) begin
                sck_r <= ~sck_r;
            end else if (~(busy_r & is_ctrl)) begin
                sck_r <= cpol;
            end
        end
    end

    // ----------------------------------------
    // Read data, latched in the setup cycle
    // ----------------------------------------
    wire [31:0] rd_mux = sel_ctrl ? {24'h000000, ctrl_r} :
                         sel_stat ? {24'h000000, transfer_done_flag_r, write_collision_flag_r, 5'h00, dbl_r} :
                         sel_data ? {24'h000000, rx_buf_r} :
                         sel_pins ? {24'h000000, busy_r, 2'b00, pins_r} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h00000000;
        end else if (psel & ~penable & ~pwrite) begin
            prdata_r <= rd_mux;
        end
    end

    assign prdata = prdata_r;
    assign pready = 1'b1;
    assign pslverr = acc & ~mapped;
    assign irq = transfer_done_flag_r & ctrl_r[`CTRL_IRQ_EN];
    assign wake = wake_r;

    // ----------------------------------------
    // Pin drive; select is a plain software output
    // ----------------------------------------
    assign link.dev_sck_o = sck_r;
    assign link.dev_sck_oe = enabled & is_ctrl & pins_r[`PIN_DIR_SCK];
    assign link.dev_mosi_o = out_r;
    assign link.dev_mosi_oe = enabled & is_ctrl & pins_r[`PIN_DIR_MOSI];
    assign link.dev_miso_o = out_r;
    assign link.dev_miso_oe = tgt_sel & pins_r[`PIN_DIR_MISO];
    assign link.dev_ss_n_o = pins_r[`PIN_SS_LEVEL];
    assign link.dev_ss_n_oe = enabled & is_ctrl & pins_r[`PIN_DIR_SS];

endmodule

// file: core/spi_port_consts.svh
// Register offsets, field positions, reset values and clock divisors of the SPI port
`ifndef SPI_PORT_CONSTS_SVH
`define SPI_PORT_CONSTS_SVH

// ----------------------------------------
// Register offsets (APB byte addresses)
// ----------------------------------------
`define ADDR_CTRL 8'h00
`define ADDR_STATUS 8'h04
`define ADDR_DATA 8'h08
`define ADDR_PINS 8'h0c

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTRL_IRQ_EN 7
`define CTRL_PORT_EN 6
`define CTRL_BIT_ORDER 5
`define CTRL_CONTROLLER 4
`define CTRL_CPOL 3
`define CTRL_CPHA 2
`define CTRL_RATE_HI 1
`define CTRL_RATE_LO 0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STAT_DONE 7
`define STAT_WRITE_COLLISION_FLAG 6
`define STAT_DOUBLE 0

// ----------------------------------------
// Pin register fields
// ----------------------------------------
`define PIN_DIR_MOSI 0
`define PIN_DIR_MISO 1
`define PIN_DIR_SCK 2
`define PIN_DIR_SS 3
`define PIN_SS_LEVEL 4
`define PIN_BUSY 7

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CTRL_RESET 8'h00
`define DOUBLE_RESET 1'b0
`define PINS_RESET 5'h10
`define DATA_RESET 8'h00

// ----------------------------------------
// SCK divisors, index {double_rate, rate_select}
// ----------------------------------------
`define SCK_DIV_0 8'd4
`define SCK_DIV_1 8'd16
`define SCK_DIV_2 8'd64
`define SCK_DIV_3 8'd128
`define SCK_DIV_4 8'd2
`define SCK_DIV_5 8'd8
`define SCK_DIV_6 8'd32
`define SCK_DIV_7 8'd64

// Far controller divisor; must stay at 16 or above
`define FAR_SCK_DIV 8'd16

`endif

// file: core/spi_port_pkg.sv
// Types of the SPI link; byte_t is shared by both ends, far_state_t is the far controller's own
package spi_port_pkg;

    typedef logic [7:0] byte_t;

    typedef enum logic [1:0] {
        FAR_IDLE = 2'b00,
        FAR_SELECT = 2'b01,
        FAR_SHIFT = 2'b10,
        FAR_RELEASE = 2'b11
    } far_state_t;

endpackage

// file: core/spi_link_if.sv
// Four-wire SPI link joining the port and the far controller
`timescale 1ns/100ps
interface spi_link_if;
    logic dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe;
    logic dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe;
    logic far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_ss_n_o, far_ss_n_oe;
    logic sck, mosi, miso, ss_n;

    // ----------------------------------------
    // Wire levels; undriven select and miso pull high
    // ----------------------------------------
    assign sck = dev_sck_oe ? dev_sck_o : (far_sck_oe ? far_sck_o : 1'b0);
    assign mosi = dev_mosi_oe ? dev_mosi_o : (far_mosi_oe ? far_mosi_o : 1'b0);
    assign ss_n = dev_ss_n_oe ? dev_ss_n_o : (far_ss_n_oe ? far_ss_n_o : 1'b1);
    assign miso = dev_miso_oe ? dev_miso_o : 1'b1;

    modport device (
        output dev_sck_o, dev_sck_oe, dev_mosi_o, dev_mosi_oe,
        output dev_miso_o, dev_miso_oe, dev_ss_n_o, dev_ss_n_oe,
        input sck, mosi, miso, ss_n
    );

    modport far (
        output far_sck_o, far_sck_oe, far_mosi_o, far_mosi_oe, far_ss_n_o, far_ss_n_oe,
        input miso
    );
endinterface

// file: core/spi_far_controller.sv
// Far-end SPI controller that selects the port and exchanges one byte
`timescale 1ns/100ps
`include "spi_port_consts.svh"

module spi_far_controller (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic start,
    input wire spi_port_pkg::byte_t tx_byte,
    input wire logic cpol,
    input wire logic cpha,
    input wire logic lsb_first,
    output logic busy,
    output logic done,
    output spi_port_pkg::byte_t rx_byte,
    spi_link_if.far link
);
    import spi_port_pkg::*;

    far_state_t state_r;
    byte_t sh_r, rx_r;
    logic [7:0] cnt_r;
    logic [2:0] bit_cnt_r;
    logic sck_r, out_r, ss_n_r, done_r, miso1_r, miso2_r;

    // Half period of the far clock; divisor kept at 16 or above
    wire [7:0] half_m1 = (`FAR_SCK_DIV >> 1) - 8'd1;
    wire tick = cnt_r == half_m1;
    wire lead = (state_r == FAR_SHIFT) & tick & (sck_r == cpol);
    wire trail = (state_r == FAR_SHIFT) & tick & (sck_r != cpol);
    wire sample = cpha ? trail : lead;
    wire setup = cpha ? lead : trail;
    wire [7:0] sh_shift = lsb_first ? {miso2_r, sh_r[7:1]} : {sh_r[6:0], miso2_r};
    wire top_bit = lsb_first ? sh_r[0] : sh_r[7];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            miso1_r <= 1'b1;
            miso2_r <= 1'b1;
        end else begin
            miso1_r <= link.miso;
            miso2_r <= miso1_r;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= FAR_IDLE;
            sh_r <= 8'h00;
            rx_r <= 8'h00;
            cnt_r <= 8'd0;
            bit_cnt_r <= 3'd0;
            sck_r <= 1'b0;
            out_r <= 1'b0;
            ss_n_r <= 1'b1;
            done_r <= 1'b0;
        end else begin
            done_r <= 1'b0;
            cnt_r <= tick ? 8'd0 : cnt_r + 8'd1;
            case (state_r)
                FAR_IDLE: begin
                    sck_r <= cpol;
                    if (start) begin
                        // Select goes low a full period before the first edge
                        ss_n_r <= 1'b0;
                        sh_r <= tx_byte;
                        out_r <= lsb_first ? tx_byte[0] : tx_byte[7];
                        bit_cnt_r <= 3'd0;
                        cnt_r <= 8'd0;
                        state_r <= FAR_SELECT;
                    end
                end
                FAR_SELECT: begin
                    if (tick) begin
                        state_r <= FAR_SHIFT;
                    end
                end
                FAR_SHIFT: begin
                    if (tick) begin
                        sck_r <= ~sck_r;
                    end
                    if (sample) begin
                        sh_r <= sh_shift;
                    end
                    if (setup) begin
                        out_r <= top_bit;
                    end
                    if (trail) begin
                        bit_cnt_r <= bit_cnt_r + 3'd1;
                        if (bit_cnt_r == 3'd7) begin
                            rx_r <= sample ? sh_shift : sh_r;
                            state_r <= FAR_RELEASE;
                        end
                    end
                end
                FAR_RELEASE: begin
                    if (tick) begin
                        ss_n_r <= 1'b1;
                        done_r <= 1'b1;
                        state_r <= FAR_IDLE;
                    end
                end
                default: begin
                    state_r <= FAR_IDLE;
                end
            endcase
        end
    end

    assign busy = state_r != FAR_IDLE;
    assign done = done_r;
    assign rx_byte = rx_r;

    // Select is driven high for one cycle before the pins are released
    wire link_drive = busy | done_r;

    assign link.far_sck_o = sck_r;
    assign link.far_sck_oe = link_drive;
    assign link.far_mosi_o = out_r;
    assign link.far_mosi_oe = link_drive;
    assign link.far_ss_n_o = ss_n_r;
    assign link.far_ss_n_oe = link_drive;

endmodule

// file: test/spi_port_props.sv
// Link checks between the SPI port and the far controller
`timescale 1ns/100ps
module spi_port_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic dev_sck_o,
    input wire logic dev_sck_oe,
    input wire logic dev_mosi_oe,
    input wire logic dev_miso_oe,
    input wire logic dev_ss_n_o,
    input wire logic far_sck_o,
    input wire logic far_sck_oe,
    input wire logic far_ss_n_o,
    input wire logic far_ss_n_oe,
    input wire logic ss_n
);
    logic [7:0] tog_r;
    logic sck_r;

    // ----------------------------------------
    // Controller clock edges while select is low
    // ----------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tog_r <= 8'h00;
            sck_r <= 1'b0;
        end else begin
            sck_r <= dev_sck_o;
            if (dev_ss_n_o) begin
                tog_r <= 8'h00;
            end else if (dev_sck_oe && dev_sck_o != sck_r) begin
                tog_r <= tog_r + 8'h01;
            end
        end
    end

    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    // ----------------------------------------
    // Properties
    // ----------------------------------------
    a_far_oe_same: assert property (far_sck_oe == far_ss_n_oe)
        else $error("far enables differ");
    a_miso_role: assert property (dev_miso_oe |-> !dev_sck_oe && !dev_mosi_oe)
        else $error("target drives controller pins");
    // Sync delay lets the port drive sck for a few cycles before the fault lands
    a_fault_release: assert property (far_sck_oe && $past(far_sck_oe, 6) |-> !dev_sck_oe)
        else $error("port still drives sck");
    a_miso_release: assert property (ss_n [*4] |-> !dev_miso_oe)
        else $error("miso driven while unselected");
    a_ss_by_sw: assert property (dev_sck_oe && $changed(dev_sck_o) |-> $stable(dev_ss_n_o))
        else $error("select moved with clock");
    a_far_ss_first: assert property ($fell(far_ss_n_o) |-> ##1 $stable(far_sck_o) [*7])
        else $error("clock before select settled");
    a_far_release: assert property ($rose(far_ss_n_o) |-> far_ss_n_oe ##1 !far_ss_n_oe)
        else $error("select not raised before release");
    a_far_rate: assert property (far_sck_oe && $past(far_sck_oe) && $changed(far_sck_o)
        |=> $stable(far_sck_o) [*7])
        else $error("far clock too fast");
    a_ctrl_bits: assert property ($rose(dev_ss_n_o) |-> tog_r[3:0] == 4'h0)
        else $error("partial byte of clock edges");
endmodule

// file: test/spi_master_slave_port_tb.sv
// Bench for the SPI port paired with the far controller
`timescale 1ns/100ps
`include "spi_port_consts.svh"
module spi_master_slave_port_tb;
    import spi_port_pkg::*;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic start = 1'b0, cpol = 1'b0, cpha = 1'b0, lsb = 1'b0, sck_q = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, irq, wake, busy, done, err;
    logic [7:0] rmo, rmi;
    byte_t tx = 8'h00, rx_byte;
    int err_total = 0, comparisons = 0, cyc = 0, tog = 0, wakes = 0, t1 = 0, t2 = 0;

    always #2.5 pclk = ~pclk;

    spi_link_if spi_link_if_i ();
    spi_port_device spi_port_device_i (.pclk, .presetn, .paddr, .psel, .penable, .pwrite,
        .pwdata, .prdata, .pready, .pslverr, .irq, .wake, .link(spi_link_if_i));
    spi_far_controller spi_far_controller_i (.pclk, .presetn, .start, .tx_byte(tx), .cpol,
        .cpha, .lsb_first(lsb), .busy, .done, .rx_byte, .link(spi_link_if_i));
    spi_port_props spi_port_props_i (.pclk, .presetn,
        .dev_sck_o(spi_link_if_i.dev_sck_o), .dev_sck_oe(spi_link_if_i.dev_sck_oe),
        .dev_mosi_oe(spi_link_if_i.dev_mosi_oe), .dev_miso_oe(spi_link_if_i.dev_miso_oe),
        .dev_ss_n_o(spi_link_if_i.dev_ss_n_o), .far_sck_o(spi_link_if_i.far_sck_o),
        .far_sck_oe(spi_link_if_i.far_sck_oe), .far_ss_n_o(spi_link_if_i.far_ss_n_o),
        .far_ss_n_oe(spi_link_if_i.far_ss_n_oe), .ss_n(spi_link_if_i.ss_n));

    // ----------------------------------------
    // Wire monitor: edges, sampled bits, wake pulses
    // ----------------------------------------
    always @(negedge pclk) begin
        // Only edges inside a frame count; pin release moves sck too
        if (spi_link_if_i.sck !== sck_q && spi_link_if_i.ss_n === 1'b0) begin
            tog++;
            if (tog == 1) t1 = cyc;
            if (tog == 2) t2 = cyc;
            if (tog[0] ^ cpha) begin
                rmo = {rmo[6:0], spi_link_if_i.mosi};
                rmi = {rmi[6:0], spi_link_if_i.miso};
            end
        end
        sck_q = spi_link_if_i.sck;
        if (wake === 1'b1) wakes++;
    end

    always @(posedge pclk) begin
        cyc++;
        if (cyc == 20000) begin
            err_total++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("comparisons %0d mismatches %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    function automatic logic [7:0] rev8(input logic [7:0] b);
        for (int i = 0; i < 8; i++) rev8[i] = b[7-i];
    endfunction

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdck(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        check(rd, exp);
    endtask

    task automatic wait_done();
        do apb(1'b0, `ADDR_STATUS, 32'h0);
        while (rd[7] !== 1'b1);
    endtask

    // Far side selects, exchanges one byte, releases
    task automatic far_xfer();
        @(posedge pclk);
        start <= 1'b1;
        @(posedge pclk);
        start <= 1'b0;
        repeat (2) @(posedge pclk);
        tog = 0;
        while (done !== 1'b1) @(negedge pclk);
    endtask

    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_regs();
        rdck(`ADDR_CTRL, 32'h0);
        rdck(`ADDR_PINS, 32'h10);
        rdck(`ADDR_DATA, 32'h0);
        apb(1'b0, 8'h10, 32'h0);
        check({rd[30:0], err}, 32'h1);
        wr(`ADDR_STATUS, 32'hffff_ffff);
        rdck(`ADDR_STATUS, 32'h1);
        $display("test regs finished");
    endtask

    // Every rate, both polarities and phases, both bit orders; collision at rate 3
    task automatic t_ctrl();
        int dv [8] = '{4, 16, 64, 128, 2, 8, 32, 64};
        logic [7:0] b;
        for (int i = 0; i < 8; i++) begin
            cpol <= i[0];
            cpha <= i[1];
            lsb <= i[2];
            b = 8'h5a ^ 8'(i * 37);
            wr(`ADDR_CTRL, {24'h0, i[0], 1'b1, i[2], 1'b1, i[0], i[1], i[1:0]});
            wr(`ADDR_STATUS, {31'h0, i[2]});
            wr(`ADDR_PINS, 32'h0d);
            tog = 0;
            wakes = 0;
            wr(`ADDR_DATA, {24'h0, b});
            if (i == 3) wr(`ADDR_DATA, 32'hff);
            wait_done();
            check(rd, {24'h0, 1'b1, i == 3, 5'h0, i[2]});
            check(irq, i[0]);
            check(tog, 16);
            check(t2 - t1, dv[i] / 2);
            check(spi_link_if_i.sck, cpol);
            check(rmo, lsb ? rev8(b) : b);
            check(wakes, 1);
            rdck(`ADDR_DATA, 32'hff);
            rdck(`ADDR_STATUS, {31'h0, i[2]});
            check(irq, 1'b0);
            wr(`ADDR_PINS, 32'h1d);
        end
        $display("test controller finished");
    endtask

    task automatic t_target();
        logic [7:0] b;
        wr(`ADDR_STATUS, 32'h0);
        wr(`ADDR_PINS, 32'h12);
        for (int m = 0; m < 4; m++) begin
            cpol <= m[0];
            cpha <= m[1];
            lsb <= m[0];
            b = 8'h3c + 8'(m);
            tx <= 8'hc3 - 8'(m * 16);
            wr(`ADDR_CTRL, {24'h0, 2'b01, m[0], 1'b0, m[0], m[1], 2'b00});
            wr(`ADDR_DATA, {24'h0, b});
            check(spi_link_if_i.dev_miso_oe, 1'b0);
            far_xfer();
            check(rx_byte, b);
            check(rmo, lsb ? rev8(tx) : tx);
            check(rmi, lsb ? rev8(b) : b);
            rdck(`ADDR_STATUS, 32'h80);
            check(irq, 1'b0);
        end
        rdck(`ADDR_DATA, {24'h0, tx});
        rdck(`ADDR_STATUS, 32'h0);
        $display("test target finished");
    endtask

    task automatic t_fault();
        cpol <= 1'b0;
        cpha <= 1'b0;
        lsb <= 1'b0;
        tx <= 8'h81;
        wr(`ADDR_CTRL, 32'h50);
        wr(`ADDR_PINS, 32'h05);
        far_xfer();
        rdck(`ADDR_CTRL, 32'h40);
        rdck(`ADDR_STATUS, 32'h80);
        $display("test fault finished");
    endtask

    initial begin
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_ctrl();
        t_target();
        t_fault();
        stop_test();
    end
endmodule
